// ### verification/irq_entry_exit_asserts.sv
// Port-level timing checks for the interrupt entry and exit unit.
module irq_entry_exit_asserts #(
    parameter int N_FLAG = 4,
    parameter int N_LEVEL = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input irq_entry_pkg::reg_req_t reg_req,
    input irq_entry_pkg::core_ctl_t core_ctl,
    input irq_entry_pkg::stack_req_t stack_req,
    input logic [7:0] reg_rdata,
    input logic global_enable,
    input irq_entry_pkg::core_report_t core_report,
    input irq_entry_pkg::alu_req_t alu_req,
    input wire logic [N_FLAG-1:0] flag_event,
    input wire logic [N_LEVEL-1:0] level_active,
    input wire logic [7:0] stack_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic run_bnd;
    logic [15:0] ra_q;
    // A boundary only counts while the sequencer runs the program.
    assign run_bnd = core_report.boundary && !core_ctl.stall;
    // Return address as it stood one edge earlier.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ra_q <= 16'h0000;
        end else begin
            ra_q <= core_report.next_pc;
        end
    end
    sequence s_entry;
        $rose(core_ctl.stall) ##1 stack_req.we;
    endsequence
    sequence s_pop2;
        stack_req.re ##1 stack_req.re;
    endsequence
    chk_entry_len: assert property (s_entry |-> ##3 core_ctl.pc_load)
        else $error("entry did not load the vector on time");
    chk_push_low: assert property (s_entry |-> stack_req.wdata == ra_q[7:0])
        else $error("first push is not the return address low byte");
    chk_push_two: assert property (s_entry |-> ##1 stack_req.we && stack_req.addr == $past(stack_req.addr) - 16'h0001)
        else $error("second push missing or misplaced");
    chk_entry_gie: assert property (s_entry |-> !global_enable)
        else $error("global enable still set on entry");
    chk_ret_len: assert property (run_bnd && core_report.kind == irq_entry_pkg::KIND_RETURN_FROM_IRQ_INSTR
        |-> ##2 s_pop2 ##2 (core_ctl.pc_load && global_enable))
        else $error("return sequence wrong");
    chk_jump_len: assert property (run_bnd && core_report.kind == irq_entry_pkg::KIND_JMP
        |-> ##4 (core_ctl.pc_load && core_ctl.pc_value == $past(core_report.jump_target, 4)))
        else $error("jump did not land in three cycles");
    chk_cli_now: assert property (run_bnd && core_report.kind == irq_entry_pkg::KIND_CLI
        |=> !global_enable && !core_ctl.stall)
        else $error("disable instruction did not block at once");
    chk_sei_next: assert property (run_bnd && core_report.kind == irq_entry_pkg::KIND_SEI
        |=> global_enable && !core_ctl.stall)
        else $error("entry taken at the enable instruction");
    chk_wake_len: assert property (core_ctl.wake |-> ##8 core_ctl.pc_load)
        else $error("wake entry length wrong");
endmodule
bind irq_entry_exit irq_entry_exit_asserts #(.N_FLAG(N_FLAG), .N_LEVEL(N_LEVEL)) chk (
    .clk(clk), .nrst(nrst), .reg_req(reg_req), .core_ctl(core_ctl), .stack_req(stack_req),
    .reg_rdata(reg_rdata), .global_enable(global_enable), .core_report(core_report), .alu_req(alu_req),
    .flag_event(flag_event), .level_active(level_active), .stack_rdata(stack_rdata));

// ### verification/stack_model.sv
// Stack memory that answers the unit's push and pop requests.
module stack_model (
    input wire logic clk,
    input irq_entry_pkg::stack_req_t req,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:511];
    initial rdata = 8'hA5;
    // Read data is valid one cycle after a pop and toggles otherwise.
    always @(posedge clk) begin
        if (req.we) begin
            mem[req.addr[8:0]] <= req.wdata;
        end
        if (req.re) begin
            rdata <= mem[req.addr[8:0]];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

// ### verification/tb.sv
// Self-checking bench for the interrupt entry and exit unit.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam irq_entry_pkg::instr_kind_t OTH = irq_entry_pkg::KIND_OTHER;
    localparam irq_entry_pkg::instr_kind_t RET = irq_entry_pkg::KIND_RETURN_FROM_IRQ_INSTR;
    localparam irq_entry_pkg::instr_kind_t SET = irq_entry_pkg::KIND_SEI;
    localparam logic [7:0] FLG = irq_entry_pkg::ADDR_FLAGS;
    logic clk, nrst;
    logic [7:0] rdata, srd;
    logic gie;
    logic [3:0] fev;
    logic [1:0] lvl;
    irq_entry_pkg::reg_req_t rq;
    irq_entry_pkg::core_ctl_t ctl;
    irq_entry_pkg::stack_req_t sq;
    irq_entry_pkg::core_report_t rep;
    irq_entry_pkg::alu_req_t alu;
    int fail_count, checked;
    irq_entry_exit #(.N_FLAG(4), .N_LEVEL(2)) dut (.clk(clk), .nrst(nrst), .reg_req(rq), .core_ctl(ctl),
        .stack_req(sq), .reg_rdata(rdata), .global_enable(gie), .core_report(rep), .alu_req(alu),
        .flag_event(fev), .level_active(lvl), .stack_rdata(srd));
    stack_model sm (.clk(clk), .req(sq), .rdata(srd));
    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic summarize();
        $display("checks=%0d errors=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        rq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        rq <= '0;
    endtask
    // Read strobe for one cycle, data compared in the following cycle.
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        rq <= '0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic bnd(input irq_entry_pkg::instr_kind_t k, input logic [15:0] ra);
        @(posedge clk);
        rep <= '{boundary: 1'b1, kind: k, next_pc: ra, jump_target: 16'h0234, sleeping: 1'b0};
        @(posedge clk);
        rep.boundary <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] v);
        @(posedge clk);
        fev <= v;
        @(posedge clk);
        fev <= 4'h0;
    endtask
    // No entry may start in the next few cycles.
    task automatic idle();
        repeat (3) @(posedge clk);
        #1;
        check({15'h0000, ctl.stall}, 16'h0000);
    endtask
    // Bounded wait for the core load pulse, then compare the loaded address.
    task automatic load(input logic [15:0] exp);
        int n;
        n = 0;
        #1;
        while (ctl.pc_load !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 30) begin
            fail_count++;
            summarize();
        end else begin
            check(ctl.pc_value, exp);
        end
    endtask
    // Main sequence.
    initial begin
        rq = '0;
        rep = '0;
        alu = '0;
        fev = 4'h0;
        lvl = 2'h0;
        nrst = 1'b0;
        fail_count = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rdc(irq_entry_pkg::ADDR_SP_LO, 8'hFF);
        rdc(irq_entry_pkg::ADDR_SP_HI, 8'h01);
        wr(8'h21, 8'h05);
        wr(8'h22, 8'h03);
        @(posedge clk);
        alu <= '{valid: 1'b1, op: irq_entry_pkg::ALU_ADD, dst: 5'h01, src: 5'h02};
        @(posedge clk);
        alu <= '0;
        rdc(8'h21, 8'h08);
        wr(irq_entry_pkg::ADDR_STATUS, 8'h03);
        pulse(4'h2);
        rdc(FLG, 8'h02);
        wr(FLG, 8'h00);
        rdc(FLG, 8'h02);
        wr(FLG, 8'h02);
        rdc(FLG, 8'h00);
        wr(irq_entry_pkg::ADDR_FLAG_EN, 8'h0F);
        pulse(4'h7);
        bnd(OTH, 16'h0100);
        idle();
        rdc(FLG, 8'h07);
        bnd(SET, 16'h0100);
        idle();
        bnd(OTH, 16'h0101);
        load(16'h0001);
        rdc(FLG, 8'h06);
        rdc(irq_entry_pkg::ADDR_STATUS, 8'h03);
        rdc(irq_entry_pkg::ADDR_SP_LO, 8'hFD);
        bnd(RET, 16'h0000);
        load(16'h0101);
        check({15'h0000, gie}, 16'h0001);
        bnd(OTH, 16'h0102);
        idle();
        bnd(OTH, 16'h0103);
        load(16'h0002);
        bnd(SET, 16'h0010);
        bnd(OTH, 16'h0011);
        load(16'h0003);
        bnd(RET, 16'h0000);
        load(16'h0011);
        bnd(RET, 16'h0000);
        load(16'h0103);
        rdc(irq_entry_pkg::ADDR_SP_LO, 8'hFF);
        bnd(OTH, 16'h0104);
        @(posedge clk);
        rep <= '{boundary: 1'b1, kind: irq_entry_pkg::KIND_CLI, next_pc: 16'h0105, jump_target: 16'h0000, sleeping: 1'b0};
        fev <= 4'h1;
        @(posedge clk);
        rep.boundary <= 1'b0;
        fev <= 4'h0;
        idle();
        rdc(FLG, 8'h01);
        wr(FLG, 8'h01);
        wr(irq_entry_pkg::ADDR_LEVEL_EN, 8'h01);
        @(posedge clk);
        lvl <= 2'h1;
        repeat (2) @(posedge clk);
        lvl <= 2'h0;
        bnd(SET, 16'h0120);
        bnd(OTH, 16'h0121);
        idle();
        lvl <= 2'h1;
        bnd(OTH, 16'h0140);
        load(16'h0005);
        lvl <= 2'h0;
        bnd(RET, 16'h0000);
        load(16'h0140);
        bnd(irq_entry_pkg::KIND_JMP, 16'h0141);
        load(16'h0234);
        @(posedge clk);
        rep.sleeping <= 1'b1;
        rep.next_pc <= 16'h0300;
        pulse(4'h8);
        load(16'h0004);
        @(posedge clk);
        rep.sleeping <= 1'b0;
        summarize();
    end
endmodule

// ### verilog/irq_entry_exit.sv
// Interrupt entry and exit sequencer with pending flags, priority, stack push and pop, and register ALU.
//
// Notes on behaviour
// RULE1 - Core logic runs directly on clk, undivided.
// RULE2 - Two-register ALU result written back same cycle.
// RULE3 - Reset and each source own distinct low vectors.
// RULE4 - Lowest vector wins; reset first, then source zero.
// RULE5 - Take source only if own and global enabled.
// RULE6 - Accepting an interrupt clears global enable.
// RULE7 - Global enable set in handler allows nesting.
// RULE8 - Return from interrupt sets global enable.
// RULE9 - Vectoring clears that source's pending flag.
// RULE10 - Writing one clears a flag; zero keeps.
// RULE11 - Flag set while disabled stays until enabled/cleared.
// RULE12 - Pending flags served by priority once enabled.
// RULE13 - Level sources request only while active.
// RULE14 - One main instruction runs after return.
// RULE15 - Status flags never saved or restored automatically.
// RULE16 - Clear-global-enable blocks even simultaneous requests.
// RULE17 - Instruction after set-global-enable runs first.
// RULE18 - Entry takes four cycles, pushing program counter.
// RULE19 - Requests wait for multi-cycle instruction completion.
// RULE20 - Wake from sleep adds four entry cycles.
// RULE21 - Return takes four cycles, pops two bytes.
// RULE22 - Vector jump takes three cycles.
// RULE23 - Entry pushes two bytes, stack pointer minus two.
module irq_entry_exit #(
    parameter int N_FLAG = 4,
    parameter int N_LEVEL = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input irq_entry_pkg::reg_req_t reg_req,
    output irq_entry_pkg::core_ctl_t core_ctl,
    output irq_entry_pkg::stack_req_t stack_req,
    output logic [7:0] reg_rdata,
    output logic global_enable,
    input irq_entry_pkg::core_report_t core_report,
    input irq_entry_pkg::alu_req_t alu_req,
    input wire logic [N_FLAG-1:0] flag_event,
    input wire logic [N_LEVEL-1:0] level_active,
    input wire logic [7:0] stack_rdata
);

    localparam int N_SRC = N_FLAG + N_LEVEL;

    // The flag and enable registers are one byte wide each.
    initial begin
        if (N_FLAG < 1 || N_FLAG > 8 || N_LEVEL < 1 || N_LEVEL > 8) begin
            $error("irq_entry_exit: N_FLAG and N_LEVEL must be 1 to 8");
        end
    end

    localparam logic [2:0] ENTRY_LAST = 3'(irq_entry_pkg::ENTRY_CYCLES - 1);
    localparam logic [2:0] WAKE_LAST = 3'(irq_entry_pkg::WAKE_EXTRA_CYCLES - 1);
    localparam logic [2:0] RET_LAST = 3'(irq_entry_pkg::RETURN_CYCLES - 1);
    localparam logic [2:0] JUMP_LAST = 3'(irq_entry_pkg::JUMP_CYCLES - 1);
    localparam logic [15:0] SP_STEP = 16'h0001;
    localparam logic [15:0] SP_FRAME = 16'(irq_entry_pkg::STACK_BYTES);

    // Whole state of the unit.
    typedef struct packed {
        irq_entry_pkg::seq_state_t st;
        logic [2:0] cnt;
        logic gie;
        logic hold_one;
        logic [7:0] status;
        logic [N_FLAG-1:0] flags;
        logic [N_FLAG-1:0] flag_en;
        logic [N_LEVEL-1:0] level_en;
        logic [15:0] sp;
        logic [15:0] ret_pc;
        logic [15:0] vector;
        logic [7:0] pop_hi;
        logic [255:0] gpr;
        irq_entry_pkg::core_ctl_t ctl;
        irq_entry_pkg::stack_req_t stk;
        logic [7:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Returns the index of the lowest set bit, the highest priority source.
    function automatic logic [3:0] first_set(input logic [N_SRC-1:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Reads one of the 32 general purpose bytes.
    function automatic logic [7:0] gpr_read(input logic [255:0] file, input logic [4:0] idx);
        return file[{idx, 3'h0} +: 8];
    endfunction

    logic [N_SRC-1:0] requests;
    logic [3:0] winner;
    logic boundary;
    logic accept;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [8:0] alu_wide;
    logic [N_FLAG-1:0] sw_clear;
    logic [N_FLAG-1:0] hw_clear;

    // Requests, priority and the acceptance decision.
    always_comb begin
        requests = {level_active & state_reg.level_en, state_reg.flags & state_reg.flag_en}; // [RULE5] [RULE13]
        winner = first_set(requests); // [RULE4] [RULE12]
        boundary = core_report.boundary && state_reg.st == irq_entry_pkg::SEQ_RUN; // [RULE19]
        // Only a plain instruction boundary may be interrupted; a clear or set of the
        // global enable at this boundary blocks it, and so does the hold after a return.
        accept = boundary && (|requests) && state_reg.gie && !state_reg.hold_one // [RULE5] [RULE14]
            && core_report.kind == irq_entry_pkg::KIND_OTHER; // [RULE16] [RULE17]
    end

    // Register ALU operands and result.
    always_comb begin
        op_a = gpr_read(state_reg.gpr, alu_req.dst);
        op_b = gpr_read(state_reg.gpr, alu_req.src);
        case (alu_req.op)
            irq_entry_pkg::ALU_ADD: alu_wide = {1'b0, op_a} + {1'b0, op_b};
            irq_entry_pkg::ALU_SUB: alu_wide = {1'b0, op_a} - {1'b0, op_b};
            irq_entry_pkg::ALU_AND: alu_wide = {1'b0, op_a & op_b};
            irq_entry_pkg::ALU_OR: alu_wide = {1'b0, op_a | op_b};
            irq_entry_pkg::ALU_XOR: alu_wide = {1'b0, op_a ^ op_b};
            irq_entry_pkg::ALU_MOV: alu_wide = {1'b0, op_b};
            default: alu_wide = 9'h000;
        endcase
    end

    // Flag clears from software and from vectoring.
    always_comb begin
        sw_clear = '0;
        if (reg_req.wr && reg_req.addr == irq_entry_pkg::ADDR_FLAGS) begin
            sw_clear = reg_req.wdata[N_FLAG-1:0]; // [RULE10]
        end
        hw_clear = '0;
        if (state_reg.st == irq_entry_pkg::SEQ_ENTRY && state_reg.cnt == ENTRY_LAST
            && state_reg.vector <= 16'(N_FLAG)) begin
            for (int i = 0; i < N_FLAG; i++) begin
                hw_clear[i] = (state_reg.vector == 16'(irq_entry_pkg::RESET_VECTOR + i + 1)); // [RULE9]
            end
        end
    end

    // Next state of the whole unit.
    always_comb begin
        state_next = state_reg;
        state_next.ctl.pc_load = 1'b0;
        state_next.ctl.wake = 1'b0;
        state_next.stk.we = 1'b0;
        state_next.stk.re = 1'b0;
        state_next.rdata = irq_entry_pkg::BYTE_ZERO;

        // New events set flags; a set in the same cycle as a clear wins.
        state_next.flags = (state_reg.flags & ~sw_clear & ~hw_clear) | flag_event; // [RULE11] [RULE9] [RULE10]

        // Register port writes.
        if (reg_req.wr) begin
            if (reg_req.addr == irq_entry_pkg::ADDR_FLAG_EN) begin
                state_next.flag_en = reg_req.wdata[N_FLAG-1:0];
            end
            if (reg_req.addr == irq_entry_pkg::ADDR_LEVEL_EN) begin
                state_next.level_en = reg_req.wdata[N_LEVEL-1:0];
            end
            if (reg_req.addr == irq_entry_pkg::ADDR_STATUS) begin
                state_next.status = reg_req.wdata;
                state_next.gie = reg_req.wdata[irq_entry_pkg::STATUS_GIE_BIT]; // [RULE7]
            end
            if (reg_req.addr == irq_entry_pkg::ADDR_SP_LO) begin
                state_next.sp[7:0] = reg_req.wdata;
            end
            if (reg_req.addr == irq_entry_pkg::ADDR_SP_HI) begin
                state_next.sp[15:8] = reg_req.wdata;
            end
            if ((reg_req.addr & irq_entry_pkg::ADDR_GPR_MASK) == irq_entry_pkg::ADDR_GPR_BASE) begin
                state_next.gpr[{reg_req.addr[4:0], 3'h0} +: 8] = reg_req.wdata;
            end
        end

        // The ALU writes its destination in the same cycle it reads the operands.
        if (alu_req.valid) begin
            state_next.gpr[{alu_req.dst, 3'h0} +: 8] = alu_wide[7:0]; // [RULE2]
            state_next.status[irq_entry_pkg::STATUS_ZERO_BIT] = (alu_wide[7:0] == 8'h00);
            state_next.status[irq_entry_pkg::STATUS_CARRY_BIT] = alu_wide[8];
        end

        // Register port reads, answered in the next cycle.
        if (reg_req.rd) begin
            case (reg_req.addr)
                irq_entry_pkg::ADDR_FLAGS: state_next.rdata = 8'(state_reg.flags);
                irq_entry_pkg::ADDR_FLAG_EN: state_next.rdata = 8'(state_reg.flag_en);
                irq_entry_pkg::ADDR_LEVEL_EN: state_next.rdata = 8'(state_reg.level_en);
                irq_entry_pkg::ADDR_STATUS: begin
                    state_next.rdata = state_reg.status;
                    state_next.rdata[irq_entry_pkg::STATUS_GIE_BIT] = state_reg.gie;
                end
                irq_entry_pkg::ADDR_SP_LO: state_next.rdata = state_reg.sp[7:0];
                irq_entry_pkg::ADDR_SP_HI: state_next.rdata = state_reg.sp[15:8];
                irq_entry_pkg::ADDR_SEQ: state_next.rdata = {state_reg.cnt, state_reg.st};
                default: begin
                    if ((reg_req.addr & irq_entry_pkg::ADDR_GPR_MASK) == irq_entry_pkg::ADDR_GPR_BASE) begin
                        state_next.rdata = gpr_read(state_reg.gpr, reg_req.addr[4:0]);
                    end
                end
            endcase
        end

        // Sequencer.
        case (state_reg.st)
            irq_entry_pkg::SEQ_RUN: begin
                state_next.cnt = 3'h0;
                if (core_report.sleeping && (|requests) && state_reg.gie && !state_reg.hold_one) begin
                    // A sleeping core is woken first, then entered.
                    state_next.st = irq_entry_pkg::SEQ_WAKE; // [RULE20]
                    state_next.gie = 1'b0; // [RULE6]
                    state_next.ret_pc = core_report.next_pc;
                    state_next.vector = 16'(irq_entry_pkg::RESET_VECTOR + 1) + 16'(winner); // [RULE3] [RULE4]
                    state_next.ctl.wake = 1'b1;
                end else if (boundary) begin
                    state_next.hold_one = 1'b0; // [RULE14]
                    case (core_report.kind)
                        irq_entry_pkg::KIND_CLI: state_next.gie = 1'b0; // [RULE16]
                        // The enable's own boundary is refused by the kind test, so the
                        // boundary of the following instruction is the first one taken.
                        irq_entry_pkg::KIND_SEI: state_next.gie = 1'b1; // [RULE17]
                        irq_entry_pkg::KIND_RETURN_FROM_IRQ_INSTR: state_next.st = irq_entry_pkg::SEQ_RET;
                        irq_entry_pkg::KIND_JMP: begin
                            state_next.st = irq_entry_pkg::SEQ_JUMP; // [RULE22]
                            state_next.ret_pc = core_report.jump_target;
                        end
                        default: begin
                            if (accept) begin
                                state_next.st = irq_entry_pkg::SEQ_ENTRY; // [RULE18]
                                state_next.gie = 1'b0; // [RULE6]
                                state_next.ret_pc = core_report.next_pc;
                                state_next.vector = 16'(irq_entry_pkg::RESET_VECTOR + 1) + 16'(winner); // [RULE3]
                            end
                        end
                    endcase
                end
            end
            irq_entry_pkg::SEQ_WAKE: begin
                state_next.cnt = state_reg.cnt + 3'h1;
                if (state_reg.cnt == WAKE_LAST) begin
                    state_next.st = irq_entry_pkg::SEQ_ENTRY; // [RULE20]
                    state_next.cnt = 3'h0;
                end
            end
            irq_entry_pkg::SEQ_ENTRY: begin
                // The status flags register is left untouched here.
                state_next.cnt = state_reg.cnt + 3'h1; // [RULE15]
                if (state_reg.cnt == 3'h0) begin
                    state_next.stk.we = 1'b1; // [RULE23]
                    state_next.stk.addr = state_reg.sp;
                    state_next.stk.wdata = state_reg.ret_pc[7:0];
                end
                if (state_reg.cnt == 3'h1) begin
                    state_next.stk.we = 1'b1; // [RULE23]
                    state_next.stk.addr = state_reg.sp - SP_STEP;
                    state_next.stk.wdata = state_reg.ret_pc[15:8];
                    state_next.sp = state_reg.sp - SP_FRAME; // [RULE23]
                end
                if (state_reg.cnt == ENTRY_LAST) begin
                    state_next.st = irq_entry_pkg::SEQ_RUN; // [RULE18]
                    state_next.cnt = 3'h0;
                    state_next.ctl.pc_load = 1'b1;
                    state_next.ctl.pc_value = state_reg.vector;
                end
            end
            irq_entry_pkg::SEQ_JUMP: begin
                state_next.cnt = state_reg.cnt + 3'h1;
                if (state_reg.cnt == JUMP_LAST) begin
                    state_next.st = irq_entry_pkg::SEQ_RUN; // [RULE22]
                    state_next.cnt = 3'h0;
                    state_next.ctl.pc_load = 1'b1;
                    state_next.ctl.pc_value = state_reg.ret_pc;
                end
            end
            irq_entry_pkg::SEQ_RET: begin
                // High byte is on top; read data returns one cycle after the read.
                state_next.cnt = state_reg.cnt + 3'h1;
                if (state_reg.cnt == 3'h0) begin
                    state_next.stk.re = 1'b1; // [RULE21]
                    state_next.stk.addr = state_reg.sp + SP_STEP;
                end
                if (state_reg.cnt == 3'h1) begin
                    state_next.stk.re = 1'b1;
                    state_next.stk.addr = state_reg.sp + SP_FRAME;
                    state_next.sp = state_reg.sp + SP_FRAME; // [RULE21]
                end
                if (state_reg.cnt == 3'h2) begin
                    state_next.pop_hi = stack_rdata;
                end
                if (state_reg.cnt == RET_LAST) begin
                    state_next.st = irq_entry_pkg::SEQ_RUN; // [RULE21]
                    state_next.cnt = 3'h0;
                    state_next.gie = 1'b1; // [RULE8]
                    state_next.hold_one = 1'b1; // [RULE14]
                    state_next.ctl.pc_load = 1'b1;
                    state_next.ctl.pc_value = {state_reg.pop_hi, stack_rdata};
                end
            end
            default: begin
                state_next.st = irq_entry_pkg::SEQ_RUN;
                state_next.cnt = 3'h0;
            end
        endcase
        state_next.ctl.stall = (state_next.st != irq_entry_pkg::SEQ_RUN);
    end

    // One register bank on the undivided core clock.
    always_ff @(posedge clk or negedge nrst) begin // [RULE1]
        if (!nrst) begin
            state_reg <= '0;
            state_reg.st <= irq_entry_pkg::SEQ_RUN;
            state_reg.sp <= irq_entry_pkg::SP_RESET;
            state_reg.status <= irq_entry_pkg::STATUS_RESET;
            state_reg.ctl.pc_load <= 1'b1; // Reset vectors the core. [RULE3]
            state_reg.ctl.pc_value <= 16'(irq_entry_pkg::RESET_VECTOR);
        end else begin
            state_reg <= state_next;
        end
    end

    assign core_ctl = state_reg.ctl;
    assign stack_req = state_reg.stk;
    assign reg_rdata = state_reg.rdata;
    assign global_enable = state_reg.gie;

endmodule

// ### verilog/irq_entry_pkg.sv
// Shared constants, encodings and carrier structs for the interrupt entry and exit unit.
package irq_entry_pkg;

    // Register port map, one byte per address.
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_FLAG_EN = 8'h01;
    localparam logic [7:0] ADDR_LEVEL_EN = 8'h02;
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ADDR_SP_LO = 8'h04;
    localparam logic [7:0] ADDR_SP_HI = 8'h05;
    localparam logic [7:0] ADDR_SEQ = 8'h06;
    localparam logic [7:0] ADDR_GPR_BASE = 8'h20;
    localparam logic [7:0] ADDR_GPR_MASK = 8'hE0;

    // Field positions in the status flags register.
    localparam int STATUS_GIE_BIT = 7;
    localparam int STATUS_ZERO_BIT = 1;
    localparam int STATUS_CARRY_BIT = 0;

    // Reset values.
    localparam logic [15:0] SP_RESET = 16'h01FF;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Sequence lengths in core clock cycles, and bytes pushed per entry.
    localparam int ENTRY_CYCLES = 4;
    localparam int WAKE_EXTRA_CYCLES = 4;
    localparam int RETURN_CYCLES = 4;
    localparam int JUMP_CYCLES = 3;
    localparam int STACK_BYTES = 2;

    // Vector of the reset; source i uses vector RESET_VECTOR + i + 1.
    localparam int RESET_VECTOR = 0;

    // Kind of instruction that the core reports at an instruction boundary.
    typedef enum logic [2:0] {
        KIND_OTHER = 3'h0,
        KIND_CLI = 3'h1,
        KIND_SEI = 3'h2,
        KIND_RETURN_FROM_IRQ_INSTR = 3'h3,
        KIND_JMP = 3'h4
    } instr_kind_t;

    // Register ALU operations.
    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_SUB = 3'h1,
        ALU_AND = 3'h2,
        ALU_OR = 3'h3,
        ALU_XOR = 3'h4,
        ALU_MOV = 3'h5
    } alu_op_t;

    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        SEQ_RUN = 5'h01,
        SEQ_WAKE = 5'h02,
        SEQ_ENTRY = 5'h04,
        SEQ_JUMP = 5'h08,
        SEQ_RET = 5'h10
    } seq_state_t;

    // Report from the core at the end of each instruction.
    typedef struct packed {
        logic boundary;
        instr_kind_t kind;
        logic [15:0] next_pc;
        logic [15:0] jump_target;
        logic sleeping;
    } core_report_t;

    // Control back to the core.
    typedef struct packed {
        logic stall;
        logic wake;
        logic pc_load;
        logic [15:0] pc_value;
    } core_ctl_t;

    // Two-operand register ALU request.
    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [4:0] dst;
        logic [4:0] src;
    } alu_req_t;

    // Stack memory access.
    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } stack_req_t;

    // Software register port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage
